/* core/orps_pkg.sv */
package orps_pkg;
    localparam int CLK_MHZ = 200;
    localparam int PULSE_US = 100;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int SETUP_US = 2;
    localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
    localparam int OEVALID_NS = 150;
    localparam int OEVALID_CYC = (OEVALID_NS * CLK_MHZ + 999) / 1000;
    localparam int MAX_RETRY = 10;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    // Supply level codes handed to the supply switcher
    localparam logic [1:0] SUP_OFF = 2'h0;
    localparam logic [1:0] SUP_READ = 2'h1;  // 5.0V on both
    localparam logic [1:0] SUP_PROG = 2'h2;  // 6.5V main, 13.0V program

    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_VCC = 4'h1, S_VPP = 4'h3, S_SETUP = 4'h2,
        S_PULSE = 4'h6, S_HOLD = 4'h7, S_VERIFY = 4'h5, S_NEXT = 4'h4,
        S_DROP = 4'hC, S_CMP = 4'hD, S_DONE = 4'hF, S_ID = 4'hE
    } orps_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic ceN;
        logic oeN;
        logic [DATA_W-1:0] dataOut;
        logic dataOe;
        logic idHv;
        logic [1:0] vccLevel;
        logic [1:0] vppLevel;
    } orps_pins_t;
endpackage

/* core/orps_programmer.sv */
`timescale 1ns/100ps
`default_nettype none
module orps_programmer #(
    parameter int LAST_ADDR = 32767,
    parameter int PULSE_CYC = orps_pkg::PULSE_CYC,
    parameter int SETUP_CYC = orps_pkg::SETUP_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic startProg,
    input wire logic startId,
    output logic [14:0] srcAddr,
    input wire logic [7:0] srcData,
    input wire logic [7:0] byteOutputs,
    output orps_pkg::orps_pins_t pins,
    output logic busy,
    output logic done,
    output logic pass,
    output logic [14:0] failAddr,
    output logic [7:0] makerCode,
    output logic [7:0] typeCode
);
    // Counters are 16 bits; refuse counts that they cannot hold
    if (LAST_ADDR < 0 || LAST_ADDR > 32767 || PULSE_CYC < 1 ||
        PULSE_CYC > 62000 || SETUP_CYC < 1 || SETUP_CYC > 65000) begin : g_bad
        $error("orps_programmer: bad parameter");
    end
    default clocking cb_main @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Three-stage input sampler; change counts when stages two and three agree
    logic [7:0] s1_r, s2_r, s3_r, rd_r, rd_nxt;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {s1_r, s2_r, s3_r, rd_r} <= 32'h00000000;
        end else begin
            s1_r <= byteOutputs;
            s2_r <= s1_r;
            s3_r <= s2_r;
            rd_r <= rd_nxt;
        end
    end
    always_comb begin
        rd_nxt = (s2_r == s3_r) ? s3_r : rd_r;
    end
    orps_pkg::orps_state_t st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [14:0] addr_r, addr_nxt;
    logic [3:0] retry_r, retry_nxt;
    logic [1:0] sup_r, sup_nxt;
    logic vppOn_r, vppOn_nxt, pass_r, pass_nxt, done_r, done_nxt;
    logic compare_r, compare_nxt, idHv_r, idHv_nxt;
    logic [14:0] fail_r, fail_nxt;
    logic [7:0] mk_r, mk_nxt, ty_r, ty_nxt;
    logic cntZero;
    // Read wait covers output valid time plus the three-flop sampler
    localparam logic [15:0 ] RDWAIT = 16'(orps_pkg::OEVALID_CYC + 4);
    assign cntZero = (cnt_r == 16'h0000);
    // Sequencer next state
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cntZero ? cnt_r : cnt_r - 16'h0001;
        addr_nxt = addr_r;
        retry_nxt = retry_r;
        sup_nxt = sup_r;
        vppOn_nxt = vppOn_r;
        pass_nxt = pass_r;
        done_nxt = done_r;
        compare_nxt = compare_r;
        fail_nxt = fail_r;
        idHv_nxt = idHv_r;
        mk_nxt = mk_r;
        ty_nxt = ty_r;
        unique case (st_r)
            orps_pkg::S_IDLE: begin
                if (startProg) begin
                    st_nxt = orps_pkg::S_VCC;
                    addr_nxt = 15'h0000;
                    sup_nxt = orps_pkg::SUP_PROG;
                    cnt_nxt = 16'(SETUP_CYC);
                    done_nxt = 1'b0;
                    pass_nxt = 1'b0;
                    compare_nxt = 1'b0;
                end else if (startId) begin
                    st_nxt = orps_pkg::S_ID;
                    sup_nxt = orps_pkg::SUP_READ;
                    idHv_nxt = 1'b1;
                    addr_nxt = 15'h0000;
                    cnt_nxt = 16'(SETUP_CYC) + RDWAIT;
                end
            end
            orps_pkg::S_VCC: if (cntZero) begin
                vppOn_nxt = 1'b1;
                st_nxt = orps_pkg::S_VPP;
                cnt_nxt = 16'(SETUP_CYC);
            end
            orps_pkg::S_VPP: if (cntZero) begin
                st_nxt = orps_pkg::S_SETUP;
                retry_nxt = 4'h0;
                cnt_nxt = 16'(SETUP_CYC);
            end
            orps_pkg::S_SETUP: if (cntZero) begin
                st_nxt = orps_pkg::S_PULSE;
                cnt_nxt = 16'(PULSE_CYC - 1);
            end
            orps_pkg::S_PULSE: if (cntZero) begin
                st_nxt = orps_pkg::S_HOLD;
                cnt_nxt = 16'(SETUP_CYC);
            end
            orps_pkg::S_HOLD: if (cntZero) begin
                st_nxt = orps_pkg::S_VERIFY;
                cnt_nxt = 16'(SETUP_CYC) + RDWAIT;
            end
            orps_pkg::S_VERIFY: if (cntZero) begin
                if (rd_r == srcData) begin
                    st_nxt = orps_pkg::S_NEXT;
                end else if (retry_r == 4'(orps_pkg::MAX_RETRY)) begin
                    st_nxt = orps_pkg::S_DROP;
                    fail_nxt = addr_r;
                end else begin
                    retry_nxt = retry_r + 4'h1;
                    st_nxt = orps_pkg::S_SETUP;
                    cnt_nxt = 16'(SETUP_CYC);
                end
            end
            orps_pkg::S_NEXT: begin
                retry_nxt = 4'h0;
                cnt_nxt = compare_r ? RDWAIT : 16'(SETUP_CYC);
                if (addr_r == 15'(LAST_ADDR)) begin
                    st_nxt = orps_pkg::S_DROP;
                    pass_nxt = 1'b1;
                end else begin
                    addr_nxt = addr_r + 15'h0001;
                    st_nxt = compare_r ? orps_pkg::S_CMP
                                       : orps_pkg::S_SETUP;
                end
            end
            orps_pkg::S_DROP: begin
                if (!pass_r || compare_r) begin
                    // Program flag first; both pin supply levels go off together one cycle later
                    vppOn_nxt = 1'b0;
                    sup_nxt = vppOn_r ? sup_r : orps_pkg::SUP_OFF;
                    if (!vppOn_r) begin
                        st_nxt = orps_pkg::S_DONE;
                        done_nxt = 1'b1;
                    end
                end else if (cntZero) begin
                    sup_nxt = orps_pkg::SUP_READ;
                    vppOn_nxt = 1'b0;
                    compare_nxt = 1'b1;
                    pass_nxt = 1'b0;
                    addr_nxt = 15'h0000;
                    st_nxt = orps_pkg::S_CMP;
                    cnt_nxt = 16'(SETUP_CYC) + RDWAIT;
                end
            end
            orps_pkg::S_CMP: if (cntZero) begin
                if (rd_r != srcData) begin
                    fail_nxt = addr_r;
                    st_nxt = orps_pkg::S_DROP;
                end else if (addr_r == 15'(LAST_ADDR)) begin
                    pass_nxt = 1'b1;
                    st_nxt = orps_pkg::S_DROP;
                end else begin
                    st_nxt = orps_pkg::S_NEXT;
                end
            end
            orps_pkg::S_DONE: if (!startProg && !startId) begin
                st_nxt = orps_pkg::S_IDLE;
            end
            orps_pkg::S_ID: if (cntZero) begin
                // Select line low then high reads both codes
                if (addr_r[0] == 1'b0) begin
                    mk_nxt = rd_r;
                    addr_nxt = 15'h0001;
                    cnt_nxt = RDWAIT;
                end else begin
                    ty_nxt = rd_r;
                    idHv_nxt = 1'b0;
                    sup_nxt = orps_pkg::SUP_OFF;
                    st_nxt = orps_pkg::S_DONE;
                    done_nxt = 1'b1;
                end
            end
            default: st_nxt = orps_pkg::S_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= orps_pkg::S_IDLE;
            cnt_r <= 16'h0000;
            addr_r <= 15'h0000;
            retry_r <= 4'h0;
            sup_r <= orps_pkg::SUP_OFF;
            {vppOn_r, pass_r, done_r, compare_r, idHv_r} <= 5'h00;
            fail_r <= 15'h0000;
            {mk_r, ty_r} <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            retry_r <= retry_nxt;
            sup_r <= sup_nxt;
            vppOn_r <= vppOn_nxt;
            pass_r <= pass_nxt;
            done_r <= done_nxt;
            compare_r <= compare_nxt;
            fail_r <= fail_nxt;
            idHv_r <= idHv_nxt;
            mk_r <= mk_nxt;
            ty_r <= ty_nxt;
        end
    end
    logic reading;
    assign reading = (st_r == orps_pkg::S_VERIFY) || (st_r == orps_pkg::S_CMP)
                     || (st_r == orps_pkg::S_ID);
    // Pin drive; data released whenever output enable is on
    always_comb begin
        pins.addr = addr_r;
        pins.ceN = !(st_r == orps_pkg::S_PULSE || reading);
        pins.oeN = !reading;
        pins.dataOut = srcData;
        pins.dataOe = (st_r == orps_pkg::S_SETUP) || (st_r == orps_pkg::S_PULSE)
                      || (st_r == orps_pkg::S_HOLD);
        pins.idHv = idHv_r;
        pins.vccLevel = sup_r;
        pins.vppLevel = vppOn_r ? orps_pkg::SUP_PROG : sup_r;
    end
    assign srcAddr = addr_r;
    assign busy = (st_r != orps_pkg::S_IDLE) && (st_r != orps_pkg::S_DONE);
    assign done = done_r;
    assign pass = pass_r;
    assign failAddr = fail_r;
    assign makerCode = mk_r;
    assign typeCode = ty_r;
    // Pulse width counted in cycles
    logic [15:0] pw_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pw_r <= 16'h0000;
        end else begin
            pw_r <= pins.ceN ? 16'h0000 : pw_r + 16'h0001;
        end
    end

    property p_pulse_width;
        (st_r == orps_pkg::S_PULSE && st_nxt != orps_pkg::S_PULSE)
            |-> pw_r == 16'(PULSE_CYC - 1);
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("program pulse width wrong");
    property p_pulse_tol;
        (st_r == orps_pkg::S_PULSE) |-> pw_r < 16'(PULSE_CYC * 105 / 100);
    endproperty
    a_pulse_tol: assert property (p_pulse_tol)
        else $error("program pulse too long");
    property p_start_addr;
        (st_r == orps_pkg::S_IDLE && startProg) |=> addr_r == 15'h0000;
    endproperty
    a_start_addr: assert property (p_start_addr)
        else $error("sequence did not start at first address");
    property p_prog_sup;
        (pins.dataOe) |-> pins.vccLevel == orps_pkg::SUP_PROG && vppOn_r;
    endproperty
    a_prog_sup: assert property (p_prog_sup)
        else $error("programming without high supplies");
    property p_retry_cap;
        retry_r <= 4'(orps_pkg::MAX_RETRY);
    endproperty
    a_retry_cap: assert property (p_retry_cap)
        else $error("too many retry pulses");
    property p_fail_stop;
        (st_r == orps_pkg::S_VERIFY && cntZero && rd_r != srcData
            && retry_r == 4'(orps_pkg::MAX_RETRY))
            |=> st_r == orps_pkg::S_DROP && failAddr == $past(addr_r);
    endproperty
    a_fail_stop: assert property (p_fail_stop)
        else $error("failed byte did not stop sequence");
    property p_vcc_first;
        vppOn_r |-> pins.vccLevel == orps_pkg::SUP_PROG;
    endproperty
    a_vcc_first: assert property (p_vcc_first)
        else $error("program supply without main supply");
    property p_oe_excl;
        !(pins.dataOe && !pins.oeN);
    endproperty
    a_oe_excl: assert property (p_oe_excl)
        else $error("output enable while driving data");
    property p_cmp_low;
        (st_r == orps_pkg::S_CMP) |-> pins.vccLevel == orps_pkg::SUP_READ
            && pins.vppLevel == orps_pkg::SUP_READ;
    endproperty
    a_cmp_low: assert property (p_cmp_low)
        else $error("final compare not at reduced supplies");
endmodule // orps_programmer
`default_nettype wire

/* sim/orps_rom_model.sv */
`timescale 1ns/100ps
`default_nettype none
module orps_rom_model #(
    parameter int PULSE_CYC = 20,
    parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] TYPE_ID = 8'hA5 // Arbitrary value
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire orps_pkg::orps_pins_t pins,
    input wire logic [14:0] slowAddr,
    input wire logic [3:0] slowNeed,
    input wire logic weakEn,
    input wire logic [14:0] weakAddr,
    output logic [7:0] byteOutputs,
    output logic [7:0] violations
);
    logic [7:0] mem [4];
    logic [3:0] pulseCnt [4];
    logic [14:0] firstAddr;
    logic [7:0] lastOut;
    logic [7:0] rd;
    logic drive;
    logic seen;
    logic [1:0] a;
    int width;
    int v;

    assign a = pins.addr[1:0];
    assign drive = !pins.ceN && !pins.oeN && !pins.dataOe;

    // Read path; a weak cell misreads only at the 5.0V levels
    always_comb begin
        rd = pins.idHv ? (pins.addr[0] ? TYPE_ID : MAKER_ID) : mem[a];
        if (weakEn && pins.addr == weakAddr &&
            pins.vccLevel == orps_pkg::SUP_READ) begin
            rd = rd ^ 8'h01;
        end
    end

    // Released bus never shows the last byte, to catch early sampling
    assign byteOutputs = drive ? rd : ~lastOut;

    // Blank part on every reset so that scenarios stay independent
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 4; i++) begin
                mem[i] <= 8'hFF;
                pulseCnt[i] <= 4'h0;
            end
            width <= 0;
            lastOut <= 8'h00;
            violations <= 8'h00;
            firstAddr <= 15'h7FFF;
            seen <= 1'b0;
        end else begin
            v = 0;
            if (drive) lastOut <= rd;
            width <= (!pins.ceN && pins.oeN) ? width + 1 : 0;
            if (pins.ceN && width > 0) begin
                pulseCnt[a] <= pulseCnt[a] + 4'h1;
                if (!seen) firstAddr <= pins.addr;
                seen <= 1'b1;
                // Slow cell takes slowNeed pulses; zero means never
                if (pins.addr != slowAddr || (slowNeed != 4'h0 &&
                    pulseCnt[a] + 4'h1 >= slowNeed)) begin
                    mem[a] <= pins.dataOut;
                end
                if (width * 100 < PULSE_CYC * 95 ||
                    width * 100 > PULSE_CYC * 105) v++;
            end
            if (!pins.ceN && pins.oeN &&
                (pins.vccLevel != orps_pkg::SUP_PROG ||
                pins.vppLevel != orps_pkg::SUP_PROG)) v++;
            if (pins.vppLevel != orps_pkg::SUP_OFF &&
                pins.vccLevel == orps_pkg::SUP_OFF) v++;
            if (!pins.oeN && pins.dataOe) v++;
            violations <= violations + 8'(v);
        end
    end
endmodule // orps_rom_model
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin \
    nErrors++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
    localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
    localparam logic [7:0] TYPEID = 8'hA5; // Arbitrary value
    logic clk, arst_n, startProg, startId, weakEn, busy, done, pass;
    logic [14:0] srcAddr, failAddr, slowAddr, weakAddr;
    logic [7:0] srcData, byteOutputs, makerCode, typeCode, violations;
    logic [3:0] slowNeed;
    orps_pkg::orps_pins_t pins;
    int nErrors = 0;
    int samplesChecked = 0;

    // Source image: never the blank value, so a missed pulse shows
    assign srcData = 8'h30 + srcAddr[7:0];

    orps_programmer #(.LAST_ADDR(3), .PULSE_CYC(20), .SETUP_CYC(4)) dut (
        .clk(clk), .arst_n(arst_n), .startProg(startProg),
        .startId(startId), .srcAddr(srcAddr), .srcData(srcData),
        .byteOutputs(byteOutputs), .pins(pins), .busy(busy), .done(done),
        .pass(pass), .failAddr(failAddr), .makerCode(makerCode),
        .typeCode(typeCode));

    orps_rom_model #(.PULSE_CYC(20), .MAKER_ID(MAKER), .TYPE_ID(TYPEID))
    mdl (
        .clk(clk), .arst_n(arst_n), .pins(pins), .slowAddr(slowAddr),
        .slowNeed(slowNeed), .weakEn(weakEn), .weakAddr(weakAddr),
        .byteOutputs(byteOutputs), .violations(violations));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("Checks %0d errors %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Fresh part and fresh controller for each scenario
    task automatic restart(input logic [14:0] sa, input logic [3:0] sn,
        input logic we);
        @(posedge clk);
        slowAddr <= sa;
        slowNeed <= sn;
        weakEn <= we;
        weakAddr <= 15'h0003;
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
    endtask

    // Start and wait for done under a bound
    task automatic run(input logic id);
        int k;
        if (id) startId <= 1'b1;
        else startProg <= 1'b1;
        k = 0;
        while (done !== 1'b1 && k < 5000) begin
            @(posedge clk);
            #1;
            k++;
            if (k == 2) `CHK(busy, 1'b1)
        end
        if (k == 5000) begin
            nErrors++;
            $display("[ERR] %0t sequence never finished", $time);
            report_and_stop();
        end
        @(posedge clk);
        startProg <= 1'b0;
        startId <= 1'b0;
        #1;
    endtask

    task automatic scen_clean();
        restart(15'h0000, 4'h1, 1'b0);
        #1;
        `CHK(pins.ceN, 1'b1)
        `CHK(pins.oeN, 1'b1)
        `CHK(pins.vppLevel, orps_pkg::SUP_OFF)
        @(posedge clk);
        run(1'b0);
        `CHK(pass, 1'b1)
        `CHK(busy, 1'b0)
        `CHK(mdl.firstAddr, 15'h0000)
        for (int a = 0; a < 4; a++) begin
            `CHK(mdl.mem[a], 8'h30 + 8'(a))
            `CHK(mdl.pulseCnt[a], 4'h1)
        end
        `CHK(violations, 8'h00)
    endtask

    // Slow cell needs three retries after its first pulse
    task automatic scen_retry();
        restart(15'h0002, 4'h4, 1'b0);
        run(1'b0);
        `CHK(pass, 1'b1)
        `CHK(mdl.pulseCnt[2], 4'h4)
        `CHK(mdl.pulseCnt[3], 4'h1)
        `CHK(violations, 8'h00)
    endtask

    // Dead cell: one pulse plus ten retries, then stop
    task automatic scen_fail();
        restart(15'h0001, 4'h0, 1'b0);
        run(1'b0);
        `CHK(pass, 1'b0)
        `CHK(failAddr, 15'h0001)
        `CHK(mdl.pulseCnt[1], 4'hB)
        `CHK(mdl.pulseCnt[2], 4'h0)
        `CHK(violations, 8'h00)
    endtask

    // Cell that verifies at program levels but misreads at 5.0V
    task automatic scen_weak();
        restart(15'h0000, 4'h1, 1'b1);
        run(1'b0);
        `CHK(mdl.pulseCnt[3], 4'h1)
        `CHK(pass, 1'b0)
        `CHK(failAddr, 15'h0003)
        `CHK(violations, 8'h00)
    endtask

    task automatic scen_id();
        restart(15'h0000, 4'h1, 1'b0);
        run(1'b1);
        `CHK(makerCode, MAKER)
        `CHK(typeCode, TYPEID)
        `CHK(mdl.pulseCnt[0], 4'h0)
        `CHK(violations, 8'h00)
    endtask

    initial begin
        arst_n = 1'b0;
        startProg = 1'b0;
        startId = 1'b0;
        slowAddr = 15'h0000;
        slowNeed = 4'h1;
        weakEn = 1'b0;
        weakAddr = 15'h0003;
        scen_clean();
        scen_retry();
        scen_fail();
        scen_weak();
        scen_id();
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
